//--- gss_gauge.sv
// Gauge end: power-on/insertion reset, initialisation timing, register file
// and operational behaviour, reached over the two-wire link.
// Assumes the host end drives the link clock; the pins are asynchronous.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ns
module gss_gauge
  import gss_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYC
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        BATT_PRESENT,
  input  wire logic [15:0] CELL_MV,
  input  wire logic [15:0] CELL_CURRENT,
  input  wire logic [15:0] THERM_TEMP,
  output logic             INIT_DONE,
  output logic [1:0]       POWER_STATE,
  output logic             SAMPLE_PULSE,
  gss_link_if.dev          link
);
  initial begin
    if (INIT_CYCLES < 1)
      $error("INIT_CYCLES must be at least one");
  end

  logic [1:0]  batt_s_q;
  logic        batt_q;
  gss_pwr_e    pwr_q;
  logic [31:0] init_cnt_q;
  logic [15:0] charge_q, pack_adj_q, mode_q, temp_q, stats_q, stat_bits_q;
  logic        init_flag_q;
  logic [7:0]  ptr_q;
  logic [1:0]  phase_q;
  logic [7:0]  lo_q;
  logic        wr_p;
  logic [15:0] wr_data;
  logic        rd_lo_q;
  logic [15:0] rd_word;
  logic [7:0]  tx_byte;
  logic        start_p, stop_p, byte_p, rd_dir, in_frame;
  logic [7:0]  rx_byte;
  logic        sensor_rst;
  logic [15:0] samp_cnt_q, samp_int_q, last_i_q, di;

  assign sensor_rst = (pwr_q == GSS_OFF) || (pwr_q == GSS_INIT);

  // Presence is a pin: two flops, then edge detection on the second
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      batt_s_q <= 2'h0;
      batt_q   <= 1'b0;
    end else begin
      batt_s_q <= {batt_s_q[0], BATT_PRESENT};
      batt_q   <= batt_s_q[1];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pwr_q      <= GSS_OFF;
      init_cnt_q <= 32'h0;
    end else if (batt_s_q[1] && !batt_q) begin
      pwr_q      <= GSS_OFF;
      init_cnt_q <= 32'h0;
    end else begin
      case (pwr_q)
        GSS_OFF: begin
          if (batt_s_q[1] && CELL_MV > RESET_RELEASE_MV)
            pwr_q <= GSS_INIT;
        end
        GSS_INIT: begin
          init_cnt_q <= init_cnt_q + 32'h1;
          if (init_cnt_q == INIT_CYCLES - 1)
            pwr_q <= GSS_SLEEP;
        end
        GSS_SLEEP: begin
          if (wr_p && ptr_q == REG_POWER_MODE && wr_data == MODE_OPERATE)
            pwr_q <= GSS_OPER;
        end
        default: begin
          if (wr_p && ptr_q == REG_POWER_MODE && wr_data == MODE_SLEEP)
            pwr_q <= GSS_SLEEP;
        end
      endcase
    end
  end

  assign INIT_DONE   = (pwr_q == GSS_SLEEP) || (pwr_q == GSS_OPER);
  assign POWER_STATE = pwr_q;

  gss_byte_rx u_rx (
    .clk      (CORE_CLK),
    .rst      (RST),
    .scl_pin  (link.scl),
    .sda_pin  (link.sda),
    .tx_byte  (tx_byte),
    .ack_en   (INIT_DONE),
    .sda_oe   (link.sda_oe_dev),
    .start_p  (start_p),
    .stop_p   (stop_p),
    .byte_p   (byte_p),
    .rx_byte  (rx_byte),
    .rd_dir   (rd_dir),
    .in_frame (in_frame)
  );

  // Frame bytes: address, pointer, data low, data high (little-endian words)
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      phase_q <= 2'h0;
      ptr_q   <= 8'h00;
      lo_q    <= 8'h00;
      rd_lo_q <= 1'b1;
    end else if (start_p) begin
      phase_q <= 2'h0;
      rd_lo_q <= 1'b1;
    end else if (byte_p && INIT_DONE) begin
      if (phase_q == 2'h0) begin
        phase_q <= 2'h1;
      end else if (rd_dir) begin
        rd_lo_q <= !rd_lo_q;
      end else if (phase_q == 2'h1) begin
        ptr_q   <= rx_byte;
        phase_q <= 2'h2;
      end else if (phase_q == 2'h2) begin
        lo_q    <= rx_byte;
        phase_q <= 2'h3;
      end else begin
        phase_q <= 2'h2;
      end
    end
  end

  assign wr_p    = byte_p && INIT_DONE && !rd_dir && in_frame && (phase_q == 2'h3);
  assign wr_data = {rx_byte, lo_q};

  always_comb begin
    if (ptr_q == REG_CHARGE)
      rd_word = charge_q;
    else if (ptr_q == REG_PACK_ADJ)
      rd_word = pack_adj_q;
    else if (ptr_q == REG_POWER_MODE)
      rd_word = (pwr_q == GSS_OPER) ? MODE_OPERATE : MODE_SLEEP;
    else if (ptr_q == REG_TEMP)
      rd_word = temp_q;
    else if (ptr_q == REG_STATUS_BIT)
      rd_word = stat_bits_q;
    else if (ptr_q == REG_INIT_FLAG)
      rd_word = {15'h0, init_flag_q};
    else if (ptr_q == REG_STATS)
      rd_word = stats_q;
    else
      rd_word = 16'h0000;
  end
  assign tx_byte = rd_lo_q ? rd_word[7:0] : rd_word[15:8];

  // Registers return to defaults while in reset or initialising
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pack_adj_q  <= PACK_ADJ_RST;
      stat_bits_q <= 16'h0000;
      init_flag_q <= 1'b1;
    end else if (sensor_rst) begin
      pack_adj_q  <= PACK_ADJ_RST;
      stat_bits_q <= 16'h0000;
      init_flag_q <= 1'b1;
    end else if (wr_p) begin
      if (ptr_q == REG_PACK_ADJ)
        pack_adj_q <= wr_data;
      if (ptr_q == REG_STATUS_BIT)
        stat_bits_q <= wr_data;
      if (ptr_q == REG_INIT_FLAG)
        init_flag_q <= wr_data[0];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      charge_q <= CHARGE_RST;
    end else if (sensor_rst) begin
      charge_q <= CHARGE_RST;
    end else if (wr_p && ptr_q == REG_PARAM_CMD && wr_data == PARAM_CMD_GO) begin
      charge_q <= gss_profile_charge(pack_adj_q);
    end
  end

  // Bit 0 of the status word selects thermistor mode; otherwise the host writes
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      temp_q <= TEMP_RST;
    end else if (sensor_rst) begin
      temp_q <= TEMP_RST;
    end else if (stat_bits_q[0]) begin
      if (SAMPLE_PULSE)
        temp_q <= THERM_TEMP;
    end else if (wr_p && ptr_q == REG_TEMP) begin
      temp_q <= wr_data;
    end
  end

  assign di = (CELL_CURRENT > last_i_q) ? CELL_CURRENT - last_i_q : last_i_q - CELL_CURRENT;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      samp_cnt_q   <= 16'h0;
      samp_int_q   <= SAMPLE_SLOW;
      last_i_q     <= 16'h0;
      SAMPLE_PULSE <= 1'b0;
    end else begin
      SAMPLE_PULSE <= 1'b0;
      if (pwr_q != GSS_OPER) begin
        samp_cnt_q <= 16'h0;
      end else if (samp_cnt_q >= samp_int_q - 16'h1) begin
        samp_cnt_q   <= 16'h0;
        SAMPLE_PULSE <= 1'b1;
        last_i_q     <= CELL_CURRENT;
        samp_int_q   <= (di > CURRENT_STEP) ? SAMPLE_FAST : SAMPLE_SLOW;
      end else begin
        samp_cnt_q <= samp_cnt_q + 16'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      stats_q <= 16'h0;
    end else if (sensor_rst) begin
      stats_q <= 16'h0;
    end else if (wr_p && ptr_q == REG_STATS) begin
      stats_q <= wr_data;
    end else if (SAMPLE_PULSE && pwr_q == GSS_OPER && stats_q != 16'hFFFF) begin
      stats_q <= stats_q + 16'h1;
    end
  end
endmodule // gss_gauge

//--- gss_pkg.sv
// Package of the gauge start-up sequencer: register map, field values and cycle counts.
// Assumes a 20 MHz core clock on both ends and an I2C-like two-wire link.
package gss_pkg;
  localparam int unsigned CORE_HZ          = 20_000_000;
  // Initialisation time budget, in microseconds, and its cycle count (rounded down)
  localparam int unsigned INIT_TIME_US     = 100;
  localparam int unsigned INIT_CYC         = (INIT_TIME_US * (CORE_HZ / 1_000_000));
  // Link clock half period made by the host, in core cycles
  // Long enough for the two sync stages on both ends before the host samples
  localparam int unsigned SCL_HALF_CYC     = 8;
  // Battery voltage threshold releasing reset, mV code
  localparam logic [15:0] RESET_RELEASE_MV = 16'h0A8C;
  // Gauge register addresses
  localparam logic [7:0]  REG_TEMP         = 8'h08;
  localparam logic [7:0]  REG_CHARGE       = 8'h0D;
  localparam logic [7:0]  REG_PARAM_CMD    = 8'h12;
  localparam logic [7:0]  REG_STATUS_BIT   = 8'h16;
  localparam logic [7:0]  REG_POWER_MODE   = 8'h15;
  localparam logic [7:0]  REG_PACK_ADJ     = 8'h0B;
  localparam logic [7:0]  REG_INIT_FLAG    = 8'h36;
  localparam logic [7:0]  REG_STATS        = 8'h24;
  localparam logic [15:0] PARAM_CMD_GO     = 16'hAA55;
  localparam logic [15:0] MODE_OPERATE     = 16'h0001;
  localparam logic [15:0] MODE_SLEEP       = 16'h0002;
  // Register defaults
  localparam logic [15:0] CHARGE_RST       = 16'h0000;
  localparam logic [15:0] PACK_ADJ_RST     = 16'h0000;
  localparam logic [15:0] TEMP_RST         = 16'h0BA6;
  // Sampling intervals in core cycles: slow when current is steady
  localparam logic [15:0] SAMPLE_FAST      = 16'h0010;
  localparam logic [15:0] SAMPLE_SLOW      = 16'h0100;
  localparam logic [15:0] CURRENT_STEP     = 16'h0040;
  // Host APB register offsets
  localparam logic [7:0]  APB_CTRL         = 8'h00;
  localparam logic [7:0]  APB_CFG          = 8'h04;
  localparam logic [7:0]  APB_STAT         = 8'h08;
  localparam logic [7:0]  APB_IRQ_STAT     = 8'h0C;
  localparam logic [7:0]  APB_IRQ_MASK     = 8'h10;
  localparam logic [7:0]  APB_CHARGE       = 8'h14;
  localparam int unsigned IRQ_DONE_BIT     = 0;
  localparam int unsigned IRQ_REINIT_BIT   = 1;
  localparam int unsigned IRQ_NACK_BIT     = 2;

  typedef enum logic [1:0] {GSS_OFF, GSS_INIT, GSS_SLEEP, GSS_OPER} gss_pwr_e;

  // Default charge level chosen by the pack adjustment setting
  function automatic logic [15:0] gss_profile_charge(input logic [15:0] adj);
    gss_profile_charge = 16'h0032 + {8'h00, adj[7:0]};
  endfunction
endpackage

//--- gss_link_if.sv
// Two-wire link between the gauge and the application processor.
// Open-drain: the bench resolves each wire as low while any side enables.
`timescale 1ns/1ns
interface gss_link_if;
  logic scl_o_host;
  logic scl_oe_host;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic scl;
  logic sda;
  assign scl = !scl_oe_host;
  assign sda = !(sda_oe_host || sda_oe_dev);
  modport dev  (input scl, input sda, output sda_oe_dev);
  modport host (input scl, input sda, output scl_o_host, output scl_oe_host, output sda_oe_host);
endinterface

//--- gss_byte_rx.sv
// Two-wire slave shifter: synchronises the pins, finds start/stop and edges,
// moves bytes and drives acknowledge and read data. Used by the gauge end.
`timescale 1ns/1ns
module gss_byte_rx (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl_pin,
  input  wire logic       sda_pin,
  input  wire logic [7:0] tx_byte,
  input  wire logic       ack_en,
  output logic            sda_oe,
  output logic            start_p,
  output logic            stop_p,
  output logic            byte_p,
  output logic [7:0]      rx_byte,
  output logic            rd_dir,
  output logic            in_frame
);
  logic [1:0] scl_s_q, sda_s_q;
  logic       scl_q, sda_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic       first_q;
  logic       rise, fall;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_pin};
      sda_s_q <= {sda_s_q[0], sda_pin};
      scl_q   <= scl_s_q[1];
      sda_q   <= sda_s_q[1];
    end
  end

  assign rise    = scl_s_q[1] && !scl_q;
  assign fall    = !scl_s_q[1] && scl_q;
  assign start_p = scl_s_q[1] && scl_q && sda_q && !sda_s_q[1];
  assign stop_p  = scl_s_q[1] && scl_q && !sda_q && sda_s_q[1];

  // Registered so that rx_byte already holds the new byte when the pulse is seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      byte_p <= 1'b0;
    else
      byte_p <= in_frame && !start_p && !stop_p && rise && (bit_q == 4'h7);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_q    <= 4'h0;
      sh_q     <= 8'h00;
      rx_byte  <= 8'h00;
      in_frame <= 1'b0;
      first_q  <= 1'b0;
      rd_dir   <= 1'b0;
      sda_oe   <= 1'b0;
    end else if (start_p) begin
      // The first clock fall after start wraps this to zero before bit 7 arrives
      bit_q    <= 4'hF;
      in_frame <= 1'b1;
      first_q  <= 1'b1;
      sda_oe   <= 1'b0;
    end else if (stop_p) begin
      in_frame <= 1'b0;
      sda_oe   <= 1'b0;
    end else if (in_frame) begin
      if (rise && bit_q < 4'h8) begin
        sh_q <= {sh_q[6:0], sda_s_q[1]};
        if (bit_q == 4'h7) begin
          rx_byte <= {sh_q[6:0], sda_s_q[1]};
          if (first_q)
            rd_dir <= sda_s_q[1];
        end
      end
      if (fall) begin
        if (bit_q == 4'h7) begin
          // Acknowledge slot: pull low when accepted, for the address byte or when not reading
          sda_oe  <= ack_en && (first_q || !rd_dir);
          bit_q   <= 4'h8;
        end else if (bit_q == 4'h8) begin
          first_q <= 1'b0;
          bit_q   <= 4'h0;
          sda_oe  <= rd_dir && !first_q ? !tx_byte[7] :
                     (rd_dir && first_q ? !tx_byte[7] : 1'b0);
        end else begin
          bit_q  <= bit_q + 4'h1;
          sda_oe <= rd_dir && !first_q ? !tx_byte[3'(6 - bit_q)] : 1'b0;
        end
      end
    end
  end
endmodule // gss_byte_rx

//--- gss_host.sv
// Host end: APB-programmed controller that runs the measurement starting flow
// over the two-wire link and reports completion and re-initialisation.
// Assumes the gauge acknowledges only after it has initialised.
`timescale 1ns/1ns
module gss_host
  import gss_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  gss_link_if.host         link
);
  typedef enum logic [2:0] {GH_IDLE, GH_START, GH_BIT, GH_ACK, GH_STOP} gss_bus_e;
  gss_bus_e    bst_q;
  logic [2:0]  step_q, nstep;
  logic [15:0] cfg_q;
  logic [2:0]  irq_st_q, irq_mask_q, ev;
  logic        busy_q, poll_q;
  logic [15:0] charge_q;
  logic [1:0]  scl_s_q, sda_s_q;
  logic [7:0]  div_q;
  logic [3:0]  bit_q;
  logic [1:0]  byte_q;
  logic [31:0] frame_q;
  logic [7:0]  rd_q;
  logic        rd_frame;
  logic        wr_acc;
  logic [31:0] frame_src;

  assign wr_acc  = PSEL && PENABLE && PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;
  assign IRQ     = |(irq_st_q & irq_mask_q);

  // Steps: pack adjust, temp mode, param cmd, operational, clear flag, poll flag
  function automatic logic [31:0] step_frame(input logic [2:0] s, input logic [15:0] c);
    case (s)
      3'h0:    step_frame = {REG_PACK_ADJ, c[7:0], 8'h00, 8'h00};
      3'h1:    step_frame = {REG_STATUS_BIT, 7'h00, c[8], 8'h00, 8'h00};
      3'h2:    step_frame = {REG_PARAM_CMD, PARAM_CMD_GO[7:0], PARAM_CMD_GO[15:8], 8'h00};
      3'h3:    step_frame = {REG_POWER_MODE, MODE_OPERATE[7:0], 8'h00, 8'h00};
      3'h4:    step_frame = {REG_INIT_FLAG, 8'h00, 8'h00, 8'h00};
      default: step_frame = {REG_INIT_FLAG, 24'h0};
    endcase
  endfunction

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
    end else begin
      scl_s_q <= {scl_s_q[0], link.scl};
      sda_s_q <= {sda_s_q[0], link.sda};
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cfg_q      <= 16'h0001;
      irq_mask_q <= 3'h0;
    end else if (wr_acc && PADDR == APB_CFG) begin
      cfg_q      <= PWDATA[15:0];
    end else if (wr_acc && PADDR == APB_IRQ_MASK) begin
      irq_mask_q <= PWDATA[2:0];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST)
      irq_st_q <= 3'h0;
    else if (wr_acc && PADDR == APB_IRQ_STAT)
      irq_st_q <= (irq_st_q & ~PWDATA[2:0]) | ev;
    else
      irq_st_q <= irq_st_q | ev;
  end

  always_comb begin
    if (PADDR == APB_CFG)
      PRDATA = {16'h0, cfg_q};
    else if (PADDR == APB_STAT)
      PRDATA = {26'h0, step_q, 2'h0, busy_q};
    else if (PADDR == APB_IRQ_STAT)
      PRDATA = {29'h0, irq_st_q};
    else if (PADDR == APB_IRQ_MASK)
      PRDATA = {29'h0, irq_mask_q};
    else if (PADDR == APB_CHARGE)
      PRDATA = {16'h0, charge_q};
    else
      PRDATA = 32'h0;
  end

  assign frame_src = step_frame(step_q, cfg_q);
  assign rd_frame = (step_q == 3'h5);
  assign nstep    = (step_q == 3'h5) ? 3'h5 : step_q + 3'h1;
  assign link.scl_o_host = 1'b0;

  // Frame: address+W, pointer, low, high for writes; pointer poll reads one byte
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      bst_q <= GH_IDLE;
      step_q <= 3'h0;
      busy_q <= 1'b0;
      poll_q <= 1'b0;
      div_q <= 8'h0;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      frame_q <= 32'h0;
      rd_q <= 8'h0;
      charge_q <= 16'h0;
      ev <= 3'h0;
      link.scl_oe_host <= 1'b0;
      link.sda_oe_host <= 1'b0;
    end else begin
      ev <= 3'h0;
      div_q <= (div_q == 8'(SCL_HALF_CYC - 1)) ? 8'h0 : div_q + 8'h1;
      case (bst_q)
        GH_IDLE: begin
          if (wr_acc && PADDR == APB_CTRL && PWDATA[0]) begin
            step_q <= 3'h0;
            busy_q <= 1'b1;
            bst_q  <= GH_START;
          end else if ((busy_q || poll_q) && div_q == 8'h0) begin
            bst_q <= GH_START;
          end
        end
        GH_START: begin
          if (div_q == 8'h0) begin
            link.sda_oe_host <= 1'b1;
            bit_q   <= 4'h0;
            byte_q  <= 2'h0;
            frame_q <= {8'hAA, frame_src[31:8]};
            bst_q   <= GH_BIT;
          end
        end
        GH_BIT: begin
          if (div_q == 8'h0) begin
            if (!link.scl_oe_host) begin
              link.scl_oe_host <= 1'b1;
            end else begin
              link.scl_oe_host <= 1'b0;
              link.sda_oe_host <= !frame_q[31] && !(rd_frame && byte_q == 2'h2);
              frame_q <= {frame_q[30:0], 1'b0};
              rd_q <= {rd_q[6:0], sda_s_q[1]};
              if (bit_q == 4'h7)
                bst_q <= GH_ACK;
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        GH_ACK: begin
          if (div_q == 8'h0) begin
            if (!link.scl_oe_host) begin
              // Clock low, data released: the gauge answers in this low phase
              link.scl_oe_host <= 1'b1;
              link.sda_oe_host <= 1'b0;
            end else begin
              link.scl_oe_host <= 1'b0;
              if (sda_s_q[1] && !(rd_frame && byte_q == 2'h2)) begin
                ev[IRQ_NACK_BIT] <= 1'b1;
                busy_q <= 1'b0;
                poll_q <= 1'b0;
                bit_q  <= 4'h1;
                bst_q  <= GH_STOP;
              end else if (byte_q == 2'h3 || (rd_frame && byte_q == 2'h2)) begin
                bit_q <= 4'h1;
                bst_q <= GH_STOP;
              end else begin
                byte_q <= byte_q + 2'h1;
                bit_q  <= 4'h0;
                bst_q  <= GH_BIT;
              end
            end
          end
        end
        default: begin
          if (div_q == 8'h0) begin
            if (bit_q != 4'h0) begin
              // Clock low first so the gauge drops its acknowledge before stop
              link.scl_oe_host <= 1'b1;
              link.sda_oe_host <= 1'b1;
              bit_q <= 4'h0;
            end else if (link.scl_oe_host) begin
              link.scl_oe_host <= 1'b0;
            end else begin
              link.sda_oe_host <= 1'b0;
              bst_q <= GH_IDLE;
              if (busy_q) begin
                step_q <= nstep;
                if (step_q == 3'h4) begin
                  busy_q <= 1'b0;
                  poll_q <= 1'b1;
                  ev[IRQ_DONE_BIT] <= 1'b1;
                end
              end else if (rd_frame && rd_q[0]) begin
                ev[IRQ_REINIT_BIT] <= 1'b1;
                poll_q <= 1'b0;
                charge_q <= 16'h0;
              end
            end
          end
        end
      endcase
    end
  end
endmodule // gss_host

//--- gss_chk.sv
// Checker of the gauge start-up sequencer: gauge pins and the two-wire link.
// Assumes one core clock domain and the active-high asynchronous reset.
`timescale 1ns/1ns
module gss_chk
  import gss_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYC
) (
  input wire logic        CORE_CLK,
  input wire logic        RST,
  input wire logic        BATT_PRESENT,
  input wire logic [15:0] CELL_MV,
  input wire logic        INIT_DONE,
  input wire logic [1:0]  POWER_STATE,
  input wire logic        SAMPLE_PULSE,
  input wire logic        IRQ,
  input wire logic        scl,
  input wire logic        sda_oe_dev
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic [15:0] init_cnt_q;
  // Counter instead of a long repetition keeps the bound at INIT_CYCLES plus two
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) init_cnt_q <= 16'h0000;
    else if (POWER_STATE == GSS_INIT) init_cnt_q <= init_cnt_q + 16'h0001;
    else init_cnt_q <= 16'h0000;
  end
  chk_insert_reset: assert property (
    $rose(BATT_PRESENT) |-> ##[1:4] POWER_STATE inside {GSS_OFF, GSS_INIT})
    else $error("insertion did not reset the gauge");
  chk_release_vth: assert property (
    POWER_STATE == GSS_OFF ##1 POWER_STATE == GSS_INIT |-> $past(CELL_MV) > RESET_RELEASE_MV)
    else $error("reset released below threshold");
  chk_init_bound: assert property (init_cnt_q <= INIT_CYCLES + 2)
    else $error("initialisation too long");
  chk_init_sleep: assert property (
    POWER_STATE == GSS_INIT ##1 POWER_STATE != GSS_INIT |-> POWER_STATE inside {GSS_SLEEP, GSS_OFF})
    else $error("initialisation did not end in sleep");
  chk_quiet_init: assert property (!INIT_DONE |-> !sda_oe_dev)
    else $error("gauge drove data before init");
  chk_sample_oper: assert property (
    SAMPLE_PULSE |-> POWER_STATE == GSS_OPER || $past(POWER_STATE) == GSS_OPER)
    else $error("sample outside operational mode");
  chk_pulse_short: assert property (SAMPLE_PULSE |=> !SAMPLE_PULSE)
    else $error("sample pulse longer than one cycle");
  chk_dev_drive_low: assert property ($rose(sda_oe_dev) |-> !scl)
    else $error("gauge took data line while clock high");
  chk_dev_free_low: assert property ($fell(sda_oe_dev) |-> !scl)
    else $error("gauge released data line while clock high");
  cov_sleep: cover property (POWER_STATE == GSS_SLEEP);
  cov_sample: cover property ($rose(SAMPLE_PULSE));
  cov_irq: cover property ($rose(IRQ));
endmodule // gss_chk

//--- tb_top.sv
// Testbench: gauge and host ends joined by the link, host driven over APB.
// Assumes zero-wait APB and a shortened initialisation count.
`timescale 1ns/1ns
module tb_top;
  import gss_pkg::*;
  logic        clk, rst, batt, psel, penable, pwrite;
  logic [15:0] cell_mv, cur, therm;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq, init_done, sample;
  logic [1:0]  pstate;
  int          error_cnt, samples_checked;
  gss_link_if gss_link_if_i ();
  gss_gauge #(.INIT_CYCLES(20)) gss_gauge_i (.CORE_CLK(clk), .RST(rst), .BATT_PRESENT(batt),
    .CELL_MV(cell_mv), .CELL_CURRENT(cur), .THERM_TEMP(therm), .INIT_DONE(init_done),
    .POWER_STATE(pstate), .SAMPLE_PULSE(sample), .link(gss_link_if_i));
  gss_host gss_host_i (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .link(gss_link_if_i));
  gss_chk #(.INIT_CYCLES(20)) gss_chk_i (.CORE_CLK(clk), .RST(rst), .BATT_PRESENT(batt),
    .CELL_MV(cell_mv), .INIT_DONE(init_done), .POWER_STATE(pstate), .SAMPLE_PULSE(sample),
    .IRQ(irq), .scl(gss_link_if_i.scl), .sda_oe_dev(gss_link_if_i.sda_oe_dev));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r);
  endtask
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("init_in_time", 32'h1, {31'h0, n < lim});
  endtask
  task automatic t_boot();
    logic [31:0] r;
    batt <= 1'b1;
    repeat (8) @(posedge clk);
    chk("state_low_cell", GSS_OFF, pstate);
    cell_mv <= RESET_RELEASE_MV + 16'h0010;
    wait_done(30);
    chk("state_sleep", GSS_SLEEP, pstate);
    rd(APB_CFG, r);
    chk("cfg_reset", 32'h1, r);
    rd(APB_CHARGE, r);
    chk("charge_reset", 32'h0, r);
    rd(8'h20, r);
    chk("unmapped", 32'h0, r);
    $display("boot test done");
  endtask
  task automatic t_flow(input logic [7:0] adj, input logic th);
    logic [31:0] r;
    int n;
    n = 0;
    wr(APB_IRQ_MASK, 32'h1);
    wr(APB_IRQ_STAT, 32'h7);
    wr(APB_CFG, {23'h0, th, adj});
    wr(APB_CTRL, 32'h1);
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk("flow_done", 32'h1, {31'h0, irq});
    chk("charge_profile", 32'h32 + adj, {16'h0, gss_gauge_i.charge_q});
    chk("state_oper", GSS_OPER, pstate);
    cur <= cur + 16'h0200;
    n = 0;
    while (sample !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk("sampling", 32'h1, {31'h0, sample});
    $display("flow test done");
  endtask
  task automatic t_irq();
    logic [31:0] r;
    wr(APB_IRQ_MASK, 32'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rd(APB_IRQ_STAT, r);
    chk("stat_sticky", 32'h1, {31'h0, r[IRQ_DONE_BIT]});
    wr(APB_IRQ_MASK, 32'h1);
    chk("irq_unmasked", 32'h1, {31'h0, irq});
    wr(APB_IRQ_STAT, 32'h1);
    chk("irq_cleared", 32'h0, {31'h0, irq});
    $display("irq test done");
  endtask
  task automatic t_reinsert();
    int p;
    p = 0;
    batt <= 1'b0;
    repeat (6) @(posedge clk);
    batt <= 1'b1;
    repeat (4) @(posedge clk);
    chk("insert_reset", 32'h0, {31'h0, init_done});
    wait_done(40);
    repeat (300) begin
      @(posedge clk);
      p += sample;
    end
    chk("no_sample_sleep", 32'h0, p);
    chk("state_sleep2", GSS_SLEEP, pstate);
    $display("reinsert test done");
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    {rst, batt, psel, penable, pwrite} = 5'b10000;
    {paddr, pwdata, error_cnt, samples_checked} = '0;
    cell_mv = 16'h0A00;
    cur = 16'h0100;
    therm = TEMP_RST;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_boot();
    t_flow(8'h10, 1'b1);
    t_irq();
    t_reinsert();
    t_flow(8'hF0, 1'b0);
    print_verdict();
  end
endmodule // tb_top
